/* core/eld_defines.svh */
// Constants of the external line event unit: sizes, register offsets and reset values
`ifndef ELD_DEFINES_SVH
`define ELD_DEFINES_SVH

// Line plan
`define ELD_NUM_LINES     19
`define ELD_NUM_EXT       16
`define ELD_NUM_GPIO      112
`define ELD_SEL_W         7
`define ELD_LINE_SUPPLY   16
`define ELD_LINE_RTC      17
`define ELD_LINE_AUX      18

// Register port widths
`define ELD_ADDR_W        8
`define ELD_DATA_W        32

// Register byte offsets
`define ELD_OFS_IRQ_EN    8'h00
`define ELD_OFS_EVT_EN    8'h04
`define ELD_OFS_RISE_EN   8'h08
`define ELD_OFS_FALL_EN   8'h0C
`define ELD_OFS_PENDING   8'h10
`define ELD_OFS_SEL_BASE  8'h14
`define ELD_SEL_WORDS     4
`define ELD_SEL_PER_WORD  4
`define ELD_SEL_FIELD     8

// Reset values
`define ELD_RST_LINES     19'h00000
`define ELD_RST_SEL       7'h00
`define ELD_RST_WORD      32'h00000000

`endif

/* core/eld_pkg.sv */
// Types shared by the external line event unit
`include "eld_defines.svh"

package eld_pkg;

    typedef logic [`ELD_NUM_LINES-1:0] eld_line_type;
    typedef logic [`ELD_SEL_W-1:0]     eld_sel_type;
    typedef logic [`ELD_ADDR_W-1:0]    eld_addr_type;
    typedef logic [`ELD_DATA_W-1:0]    eld_word_type;
    typedef logic [`ELD_NUM_GPIO-1:0]  eld_gpio_type;

    // Sticky flag update: a set in the same cycle as a clear wins
    function automatic eld_line_type eld_sticky(input eld_line_type old_v,
                                                input eld_line_type set_v,
                                                input eld_line_type clr_v);
        eld_sticky = (old_v & ~clr_v) | set_v;
    endfunction : eld_sticky

endpackage : eld_pkg

/* core/eld_catch_if.sv */
// Edge report carried from one line catcher to the core logic
`timescale 1ns/10ps

interface eld_catch_if;
    logic rise_pulse;   // One-cycle pulse per caught rising edge
    logic fall_pulse;   // One-cycle pulse per caught falling edge
    logic rise_async;   // Rising edge caught, not yet seen by core_clk
    logic fall_async;   // Falling edge caught, not yet seen by core_clk

    modport catcher (output rise_pulse, output fall_pulse, output rise_async, output fall_async);
    modport core    (input rise_pulse, input fall_pulse, input rise_async, input fall_async);
endinterface : eld_catch_if

/* core/eld_edge_catch.sv */
// One line catcher: edges clocked by the line itself, handed to core_clk by toggle crossing
`timescale 1ns/10ps

module eld_edge_catch (
    input  wire logic   core_clk,   // Core clock
    input  wire logic   rst,        // Reset: synchronous for the core_clk flops, clears the toggles asynchronously
    input  wire logic   line_in,    // Raw line, any width of pulse
    eld_catch_if.catcher rpt        // Edge report
);
    logic rise_tgl;
    logic fall_tgl;
    logic rise_s1_reg, rise_s2_reg, rise_last_reg;
    logic fall_s1_reg, fall_s2_reg, fall_last_reg;
    logic rise_last_next, fall_last_next;

    // Toggles clocked by the line need no core clock, so short pulses and Stop mode are covered
    always_ff @(posedge line_in or posedge rst) begin
        if (rst) begin
            rise_tgl <= 1'b0;
        end else begin
            rise_tgl <= ~rise_tgl;
        end
    end

    always_ff @(negedge line_in or posedge rst) begin
        if (rst) begin
            fall_tgl <= 1'b0;
        end else begin
            fall_tgl <= ~fall_tgl;
        end
    end

    // Last toggle value already reported
    always_comb begin
        rise_last_next = rise_s2_reg;
        fall_last_next = fall_s2_reg;
    end

    // Two-stage synchronisers and reported copies
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rise_s1_reg   <= 1'b0;
            rise_s2_reg   <= 1'b0;
            rise_last_reg <= 1'b0;
            fall_s1_reg   <= 1'b0;
            fall_s2_reg   <= 1'b0;
            fall_last_reg <= 1'b0;
        end else begin
            rise_s1_reg   <= rise_tgl;
            rise_s2_reg   <= rise_s1_reg;
            rise_last_reg <= rise_last_next;
            fall_s1_reg   <= fall_tgl;
            fall_s2_reg   <= fall_s1_reg;
            fall_last_reg <= fall_last_next;
        end
    end

    // Two edges of one kind within a core cycle cancel; one report per edge otherwise
    assign rpt.rise_pulse = rise_s2_reg ^ rise_last_reg;
    assign rpt.fall_pulse = fall_s2_reg ^ fall_last_reg;
    // Wake path looks straight at the toggle so it works with core_clk stopped
    assign rpt.rise_async = rise_tgl ^ rise_last_reg;
    assign rpt.fall_async = fall_tgl ^ fall_last_reg;

endmodule : eld_edge_catch

/* core/eld_line_unit.sv */
// External line event unit: edge lines, pin selection, masks, pending flags and register port
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "eld_defines.svh"

// How it works
// - Nineteen edge lines, each may raise an interrupt or an event request.
// - Per line, rising, falling or both edges are chosen by two enable bits.
// - Per line masks stop requests of that line only.
// - Each detected edge sets a per-line pending bit readable by software.
// - Edges are caught by flops clocked by the line, so short pulses count.
// - Each of 16 external lines picks one of 112 pins by a select field.
// - Any enabled line can raise wake without core_clk running.
// - Lines 0-15 are pins, 16 supply monitor, 17 clock alarm, 18 auxiliary.
module eld_line_unit (
    input  wire logic                  core_clk,                    // 100 MHz clock
    input  wire logic                  rst,                         // Active high reset: synchronous for the flops, clears the catcher toggles asynchronously
    input  wire eld_pkg::eld_gpio_type gpio_in,                     // General-purpose pin levels
    input  wire logic                  supply_voltage_monitor_out,  // Supply monitor output
    input  wire logic                  rtc_alarm_in,                // Real-time-clock alarm
    input  wire logic                  aux_line_in,                 // Spare internal source
    input  wire eld_pkg::eld_addr_type reg_addr,                    // Register byte address
    input  wire eld_pkg::eld_word_type reg_wdata,                   // Write data
    input  wire logic                  reg_wr,                      // Write strobe
    input  wire logic                  reg_rd,                      // Read strobe
    output      eld_pkg::eld_word_type reg_rdata,                   // Read data, cycle after strobe
    output      eld_pkg::eld_line_type line_irq,                    // Per-line requests to irq controller
    output      eld_pkg::eld_line_type line_event,                  // Per-line one-cycle event pulses
    output      logic                  irq_out,                     // Level interrupt, any unmasked pending
    output      logic                  wake_req                     // Wake request, valid with clock stopped
);
    import eld_pkg::*;

    eld_line_type irq_en_reg, irq_en_next;
    eld_line_type evt_en_reg, evt_en_next;
    eld_line_type rise_en_reg, rise_en_next;
    eld_line_type fall_en_reg, fall_en_next;
    eld_line_type pend_reg, pend_next;
    eld_line_type evt_reg, evt_next;
    eld_line_type irq_vec_reg, irq_vec_next;
    logic         irq_reg, irq_next;
    eld_word_type rdata_reg, rdata_next;
    eld_sel_type  sel_reg [`ELD_NUM_EXT];
    eld_sel_type  sel_next [`ELD_NUM_EXT];

    eld_line_type src;
    eld_line_type rise_vec, fall_vec, rise_async, fall_async;
    eld_line_type hit;
    eld_line_type clr;

    // Pin picked for one external line; codes past the last pin give a quiet low
    function automatic logic eld_pick(input eld_gpio_type pins, input eld_sel_type sel);
        eld_pick = 1'b0;
        for (int k = 0; k < `ELD_NUM_GPIO; k++) begin
            if (sel == k[`ELD_SEL_W-1:0]) begin
                eld_pick = pins[k];
            end
        end
    endfunction : eld_pick

    // Index of the select word at an address, or all ones if none
    function automatic logic [2:0] eld_sel_word(input eld_addr_type a);
        eld_sel_word = 3'h7;
        for (int w = 0; w < `ELD_SEL_WORDS; w++) begin
            if (a == `ELD_OFS_SEL_BASE + 8'(4 * w)) begin
                eld_sel_word = 3'(w);
            end
        end
    endfunction : eld_sel_word

    // Source multiplexing; changing a select may itself look like an edge
    always_comb begin
        src = `ELD_RST_LINES;
        for (int j = 0; j < `ELD_NUM_EXT; j++) begin
            src[j] = eld_pick(gpio_in, sel_reg[j]);
        end
        src[`ELD_LINE_SUPPLY] = supply_voltage_monitor_out;
        src[`ELD_LINE_RTC]    = rtc_alarm_in;
        src[`ELD_LINE_AUX]    = aux_line_in;
    end

    // One catcher per line
    for (genvar g = 0; g < `ELD_NUM_LINES; g++) begin : g_line
        eld_catch_if cif ();
        eld_edge_catch u_catch (
            .core_clk (core_clk),
            .rst      (rst),
            .line_in  (src[g]),
            .rpt      (cif.catcher)
        );
        assign rise_vec[g]   = cif.rise_pulse;
        assign fall_vec[g]   = cif.fall_pulse;
        assign rise_async[g] = cif.rise_async;
        assign fall_async[g] = cif.fall_async;
    end

    // Edge selection: both enables set gives both edges
    assign hit = (rise_vec & rise_en_reg) | (fall_vec & fall_en_reg);

    // Software clear of pending bits by writing ones
    assign clr = (reg_wr && reg_addr == `ELD_OFS_PENDING) ?
                 reg_wdata[`ELD_NUM_LINES-1:0] : `ELD_RST_LINES;

    // Configuration writes
    always_comb begin
        irq_en_next  = irq_en_reg;
        evt_en_next  = evt_en_reg;
        rise_en_next = rise_en_reg;
        fall_en_next = fall_en_reg;
        for (int j = 0; j < `ELD_NUM_EXT; j++) begin
            sel_next[j] = sel_reg[j];
        end
        if (reg_wr) begin
            case (reg_addr)
                `ELD_OFS_IRQ_EN:  irq_en_next  = reg_wdata[`ELD_NUM_LINES-1:0];
                `ELD_OFS_EVT_EN:  evt_en_next  = reg_wdata[`ELD_NUM_LINES-1:0];
                `ELD_OFS_RISE_EN: rise_en_next = reg_wdata[`ELD_NUM_LINES-1:0];
                `ELD_OFS_FALL_EN: fall_en_next = reg_wdata[`ELD_NUM_LINES-1:0];
                default: begin
                    for (int j = 0; j < `ELD_NUM_EXT; j++) begin
                        if (eld_sel_word(reg_addr) == 3'(j / `ELD_SEL_PER_WORD)) begin
                            sel_next[j] = reg_wdata[(j % `ELD_SEL_PER_WORD) * `ELD_SEL_FIELD +: `ELD_SEL_W];
                        end
                    end
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_en_reg  <= `ELD_RST_LINES;
            evt_en_reg  <= `ELD_RST_LINES;
            rise_en_reg <= `ELD_RST_LINES;
            fall_en_reg <= `ELD_RST_LINES;
            for (int j = 0; j < `ELD_NUM_EXT; j++) begin
                sel_reg[j] <= `ELD_RST_SEL;
            end
        end else begin
            irq_en_reg  <= irq_en_next;
            evt_en_reg  <= evt_en_next;
            rise_en_reg <= rise_en_next;
            fall_en_reg <= fall_en_next;
            for (int j = 0; j < `ELD_NUM_EXT; j++) begin
                sel_reg[j] <= sel_next[j];
            end
        end
    end

    // Pending, requests and events; a new edge beats a clear in the same cycle
    always_comb begin
        pend_next    = eld_sticky(pend_reg, hit, clr);
        irq_vec_next = pend_next & irq_en_next;
        irq_next     = |irq_vec_next;
        evt_next     = hit & evt_en_reg;
    end

    // Pending flags and registered requests
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_reg    <= `ELD_RST_LINES;
            irq_vec_reg <= `ELD_RST_LINES;
            irq_reg     <= 1'b0;
            evt_reg     <= `ELD_RST_LINES;
        end else begin
            pend_reg    <= pend_next;
            irq_vec_reg <= irq_vec_next;
            irq_reg     <= irq_next;
            evt_reg     <= evt_next;
        end
    end

    // Read data, one cycle after the strobe; unmapped addresses read zero
    always_comb begin
        rdata_next = `ELD_RST_WORD;
        if (reg_rd) begin
            case (reg_addr)
                `ELD_OFS_IRQ_EN:  rdata_next = {13'h0000, irq_en_reg};
                `ELD_OFS_EVT_EN:  rdata_next = {13'h0000, evt_en_reg};
                `ELD_OFS_RISE_EN: rdata_next = {13'h0000, rise_en_reg};
                `ELD_OFS_FALL_EN: rdata_next = {13'h0000, fall_en_reg};
                `ELD_OFS_PENDING: rdata_next = {13'h0000, pend_reg};
                default: begin
                    for (int j = 0; j < `ELD_NUM_EXT; j++) begin
                        if (eld_sel_word(reg_addr) == 3'(j / `ELD_SEL_PER_WORD)) begin
                            rdata_next[(j % `ELD_SEL_PER_WORD) * `ELD_SEL_FIELD +: `ELD_SEL_W] = sel_reg[j];
                        end
                    end
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= `ELD_RST_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata  = rdata_reg;
    assign line_irq   = irq_vec_reg;
    assign line_event = evt_reg;
    assign irq_out    = irq_reg;
    // Combinational on purpose: the catcher toggles move with no clock in Stop mode
    assign wake_req   = |(((rise_async & rise_en_reg) | (fall_async & fall_en_reg)) &
                          (irq_en_reg | evt_en_reg)) | irq_reg;

    // Interrupt level follows the unmasked pending bits
    chk_irq_level_follow: assert property (@(posedge core_clk) disable iff (rst)
        irq_out == |(pend_reg & irq_en_reg))
        else $error("irq_out disagrees with unmasked pending bits");

    // Enabled edge sets its pending bit at the next edge
    chk_pend_set_edge: assert property (@(posedge core_clk) disable iff (rst)
        (hit != `ELD_RST_LINES) |=> ((pend_reg & $past(hit)) == $past(hit)))
        else $error("detected edge did not set pending");

    // Pending never sets without an enabled edge
    chk_pend_cause_edge: assert property (@(posedge core_clk) disable iff (rst)
        ((pend_reg & ~$past(pend_reg)) & ~$past(hit)) == `ELD_RST_LINES)
        else $error("pending bit set with no enabled edge");

    // Pending bit held until a one is written to it
    chk_pend_sticky_hold: assert property (@(posedge core_clk) disable iff (rst)
        ((($past(pend_reg) & ~pend_reg) & ~$past(clr)) == `ELD_RST_LINES))
        else $error("pending bit dropped without a clear");

    // Disabled edge kinds never count
    chk_edge_kind_gate: assert property (@(posedge core_clk) disable iff (rst)
        ((pend_reg & ~$past(pend_reg)) &
         ~(($past(rise_vec) & $past(rise_en_reg)) | ($past(fall_vec) & $past(fall_en_reg)))) == `ELD_RST_LINES)
        else $error("pending set by an edge kind that is not enabled");

    // Event pulse only on event-enabled lines, one cycle after the edge
    chk_event_mask_gate: assert property (@(posedge core_clk) disable iff (rst)
        ##1 line_event == ($past(hit) & $past(evt_en_reg)))
        else $error("event pulse not tied to an enabled edge");

    // Pending read returns the pending bits in the next cycle
    chk_read_pend_value: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `ELD_OFS_PENDING) |=>
        reg_rdata == {13'h0000, $past(pend_reg)})
        else $error("pending read returned wrong data");

    // Write to the first select word loads the select field of line 0
    chk_sel_steer_pin: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == `ELD_OFS_SEL_BASE) |=>
        sel_reg[0] == $past(reg_wdata[`ELD_SEL_W-1:0]))
        else $error("select write did not take effect");

    // Supply monitor and clock alarm lines wired to their own sources
    chk_internal_src_map: assert property (@(posedge core_clk) disable iff (rst)
        src[`ELD_LINE_SUPPLY] == supply_voltage_monitor_out && src[`ELD_LINE_RTC] == rtc_alarm_in)
        else $error("internal line source miswired");

    // Line requests are the pending bits that are not masked
    chk_line_irq_match: assert property (@(posedge core_clk) disable iff (rst)
        line_irq == (pend_reg & irq_en_reg))
        else $error("line request disagrees with unmasked pending bits");

    // Read data stay zero unless a read strobe came the cycle before
    chk_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == `ELD_RST_WORD)
        else $error("read data not zero outside a read");

    // Line registers read zero above the last line
    chk_rdata_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr < `ELD_OFS_SEL_BASE) |=> reg_rdata[`ELD_DATA_W-1:`ELD_NUM_LINES] == '0)
        else $error("unused read data bits not zero");

    // A written one clears its pending bit when no new edge comes with it
    chk_pend_clear_takes: assert property (@(posedge core_clk) disable iff (rst)
        ((clr & ~hit & pend_reg) != `ELD_RST_LINES) |=>
        ((pend_reg & $past(clr & ~hit)) == `ELD_RST_LINES))
        else $error("pending bit not cleared by a written one");

    // Interrupt mask write takes effect at the next edge
    chk_irq_en_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == `ELD_OFS_IRQ_EN) |=> irq_en_reg == $past(reg_wdata[`ELD_NUM_LINES-1:0]))
        else $error("interrupt mask write did not take effect");

    // Event mask write takes effect at the next edge
    chk_evt_en_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == `ELD_OFS_EVT_EN) |=> evt_en_reg == $past(reg_wdata[`ELD_NUM_LINES-1:0]))
        else $error("event mask write did not take effect");

    // Rising edge enable write takes effect at the next edge
    chk_rise_en_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == `ELD_OFS_RISE_EN) |=> rise_en_reg == $past(reg_wdata[`ELD_NUM_LINES-1:0]))
        else $error("rising enable write did not take effect");

    // Falling edge enable write takes effect at the next edge
    chk_fall_en_write: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == `ELD_OFS_FALL_EN) |=> fall_en_reg == $past(reg_wdata[`ELD_NUM_LINES-1:0]))
        else $error("falling enable write did not take effect");

    // A raised interrupt keeps wake raised, so a halted core still sees it
    chk_wake_on_irq: assert property (@(posedge core_clk) disable iff (rst)
        irq_out |-> wake_req)
        else $error("wake request low while the interrupt is high");

endmodule : eld_line_unit

/* tb/eld_irq_sink.sv */
// Model of the event counter and wake-up logic that take the unit's event pulses and wake request
`timescale 1ns/10ps

module eld_irq_sink (
    input  wire logic                  core_clk,    // Core clock
    input  wire logic                  rst,         // Synchronous reset
    input  wire eld_pkg::eld_line_type line_event,  // Per-line event pulses
    input  wire logic                  wake_req,    // Wake request level
    output logic [7:0]                 evt_cnt_reg, // Event pulses taken since reset
    output logic                       wake_reg     // Wake request has been seen
);
    import eld_pkg::*;
    logic [7:0] evt_cnt_next;
    logic       wake_next;

    // Every event pulse is one cycle, so each high bit per cycle is one event
    always_comb begin
        evt_cnt_next = evt_cnt_reg + 8'($countones(line_event));
        wake_next    = wake_reg | wake_req;
    end

    // Register the counts
    always_ff @(posedge core_clk) begin
        if (rst) begin
            evt_cnt_reg <= 8'h00;
            wake_reg    <= 1'b0;
        end else begin
            evt_cnt_reg <= evt_cnt_next;
            wake_reg    <= wake_next;
        end
    end
endmodule : eld_irq_sink

/* tb/external_line_event_detector_bench.sv */
// Bench of the external line event unit: registers, edge modes, masks, pin select, wake
`timescale 1ns/10ps
`include "eld_defines.svh"

module external_line_event_detector_bench;
    import eld_pkg::*;
    logic         core_clk;
    logic         rst;
    logic         clk_run;
    eld_gpio_type gpio_in;
    logic         supply_voltage_monitor_out;
    logic         rtc_alarm_in;
    logic         aux_line_in;
    eld_addr_type reg_addr;
    eld_word_type reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    eld_word_type reg_rdata;
    eld_line_type line_irq;
    eld_line_type line_event;
    logic         irq_out;
    logic         wake_req;
    logic [7:0]   evt_cnt;
    logic         wake_seen;
    eld_word_type rd;
    int           n_fail;
    int           samples_checked;

    eld_line_unit dut (.core_clk(core_clk), .rst(rst), .gpio_in(gpio_in),
        .supply_voltage_monitor_out(supply_voltage_monitor_out), .rtc_alarm_in(rtc_alarm_in),
        .aux_line_in(aux_line_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_irq(line_irq), .line_event(line_event),
        .irq_out(irq_out), .wake_req(wake_req));
    eld_irq_sink sink (.core_clk(core_clk), .rst(rst), .line_event(line_event), .wake_req(wake_req),
        .evt_cnt_reg(evt_cnt), .wake_reg(wake_seen));

    // Clock can be halted to stand in for Stop mode
    initial begin
        core_clk = 1'b0;
        forever #5 if (clk_run) core_clk = ~core_clk;
    end

    task automatic check(input eld_word_type seen, input eld_word_type exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Strobe drops at the next edge, so back-to-back calls leave one idle cycle
    task automatic wr(input eld_addr_type a, input eld_word_type d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdr(input eld_addr_type a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdr

    // Sources 0..111 are pins, 112 supply monitor, 113 clock alarm, 114 auxiliary
    task automatic set_src(input int s, input logic v);
        if (s < `ELD_NUM_GPIO) gpio_in[s] <= v;
        else if (s == 112) supply_voltage_monitor_out <= v;
        else if (s == 113) rtc_alarm_in <= v;
        else aux_line_in <= v;
    endtask : set_src

    // Pulse far narrower than a clock period
    task automatic pulse(input int s);
        @(posedge core_clk);
        set_src(s, 1'b1);
        #3 set_src(s, 1'b0);
    endtask : pulse

    // Edge reaches pending within three cycles
    task automatic settle;
        repeat (4) @(posedge core_clk);
    endtask : settle

    // Pending must match, then the flags seen are cleared by writing ones
    task automatic pend(input eld_line_type e);
        rdr(`ELD_OFS_PENDING);
        check(rd, {13'h0000, e});
        wr(`ELD_OFS_PENDING, {13'h0000, e});
        rdr(`ELD_OFS_PENDING);
        check(rd, 32'h00000000);
    endtask : pend

    task automatic t_regs;
        for (int a = 0; a <= 32; a += 4) begin
            rdr(8'(a));
            check(rd, `ELD_RST_WORD);
        end
        wr(8'h40, 32'hFFFFFFFF);
        rdr(8'h40);
        check(rd, 32'h00000000);
        wr(`ELD_OFS_IRQ_EN, 32'hFFFFFFFF);
        rdr(`ELD_OFS_IRQ_EN);
        check(rd, 32'h0007FFFF);
        wr(`ELD_OFS_IRQ_EN, 32'h00000000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_modes;
        logic [1:0] modes [3] = '{2'b10, 2'b01, 2'b11};
        for (int m = 0; m < 3; m++) begin
            wr(`ELD_OFS_RISE_EN, {31'h0, modes[m][1]});
            wr(`ELD_OFS_FALL_EN, {31'h0, modes[m][0]});
            set_src(0, 1'b1);
            settle();
            pend({18'h0, modes[m][1]});
            set_src(0, 1'b0);
            settle();
            pend({18'h0, modes[m][0]});
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_mask;
        wr(`ELD_OFS_FALL_EN, 32'h00000000);
        wr(`ELD_OFS_IRQ_EN, 32'h00000002);
        pulse(0);
        settle();
        check({31'h0, irq_out}, 32'h0);
        wr(`ELD_OFS_IRQ_EN, 32'h00000001);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq_out}, 32'h1);
        check({13'h0, line_irq}, 32'h1);
        pend(19'h00001);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq_out}, 32'h0);
        $display("test mask done");
    endtask : t_mask

    task automatic t_select;
        wr(`ELD_OFS_RISE_EN, 32'h00000000);
        wr(8'h18, 32'h00006F00);
        rdr(8'h18);
        check(rd, 32'h00006F00);
        wr(`ELD_OFS_SEL_BASE, 32'h00000081);
        rdr(`ELD_OFS_SEL_BASE);
        check(rd, 32'h00000001);
        settle();
        pend(19'h00000);
        wr(`ELD_OFS_RISE_EN, 32'h00000020);
        pulse(0);
        settle();
        pend(19'h00000);
        pulse(111);
        settle();
        pend(19'h00020);
        $display("test select done");
    endtask : t_select

    task automatic t_internal;
        logic [7:0] c0;
        wr(`ELD_OFS_RISE_EN, 32'h00070000);
        for (int s = 0; s < 3; s++) begin
            pulse(112 + s);
            settle();
            pend(19'h10000 << s);
        end
        wr(`ELD_OFS_EVT_EN, 32'h00010000);
        c0 = evt_cnt;
        pulse(112);
        pulse(113);
        settle();
        check({24'h0, evt_cnt}, {24'h0, c0 + 8'h01});
        pend(19'h30000);
        $display("test internal done");
    endtask : t_internal

    task automatic t_wake;
        // Mid-run reset clears the model's wake flag, so the wake seen later is this test's own
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        check({31'h0, wake_seen}, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        wr(`ELD_OFS_RISE_EN, 32'h00020000);
        wr(`ELD_OFS_IRQ_EN, 32'h00020000);
        @(negedge core_clk);
        clk_run = 1'b0;
        #20 rtc_alarm_in = 1'b1;
        #2 check({31'h0, wake_req}, 32'h1);
        check({31'h0, irq_out}, 32'h0);
        #20 clk_run = 1'b1;
        settle();
        check({31'h0, wake_seen}, 32'h1);
        set_src(113, 1'b0);
        pend(19'h20000);
        check({31'h0, wake_req}, 32'h0);
        $display("test wake done");
    endtask : t_wake

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Tests take well under a thousand cycles
    initial begin
        #50000;
        n_fail++;
        close_out();
    end

    initial begin
        n_fail = 0;
        samples_checked = 0;
        clk_run = 1'b1;
        rst = 1'b0;
        gpio_in = '0;
        supply_voltage_monitor_out = 1'b0;
        rtc_alarm_in = 1'b0;
        aux_line_in = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Reset rises after time zero so the line-clocked toggles see a clean edge
        #1 rst = 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_mask();
        t_select();
        t_internal();
        t_wake();
        close_out();
    end
endmodule : external_line_event_detector_bench
